// file: hw/e1_tx_pkg.sv
// Contract
// - Insert alignment patterns and CRC4 codes
// - Format channel, signaling data; insert alarms
// - Single continuous 2.048 MHz transmit clock
// - 256 kHz channel clock marks slots
// - Channel data sampled at falling edges
// - Multiframe sync rise restarts multiframe count
// - Multiframe sync low: counter free-runs
// - Frame sync rise sets frame boundary
// - Frame sync low: boundaries from multiframe
// - Multiframe out high during frame 0
// - Extra bits sampled TS16 frame0 bits 5,7,8
// - Signaling marker high during slot 16
// - Signaling data inserted into slot 16
// - International bit at TS0 bit 1
// - National bits at TS0 bits 4-8
// - Alignment marker high in FAS frames
// - Bipolar outputs change on rising edges
// - Host mode: serial port, 14 registers; here host_mode_in only gates CRC4, international and national bits
// - Hardware mode disables host-only features
package e1_tx_pkg;
  localparam int unsigned SYS_CLK_HZ     = 50_000_000;
  localparam int unsigned LINE_BIT_HZ    = 2_048_000;
  localparam int unsigned SLOTS_PER_FRM  = 32;
  localparam int unsigned BITS_PER_SLOT  = 8;
  localparam int unsigned FRMS_PER_MF    = 16;
  localparam logic [4:0]  SLOT_ALIGN     = 5'h00;
  localparam logic [4:0]  SLOT_SIG       = 5'h10;
  localparam logic [7:0]  FAS_WORD       = 8'h1B;
  localparam logic [7:0]  CAS_MF_WORD    = 8'h00;
  localparam logic [7:0]  AIS_WORD       = 8'hFF;
  localparam logic [3:0]  CRC4_POLY      = 4'h3;
  localparam logic [3:0]  CRC_FRAME_BITS = 4'h0;
endpackage

// file: hw/e1_tx_bit_if.sv
`timescale 1ns/1ns
interface e1_tx_bit_if;
  logic valid;
  logic ready;
  logic data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hw/e1_tx_skid.sv
`timescale 1ns/1ns
// Two-entry buffer, no loss when sink stalls
module e1_tx_skid (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  e1_tx_bit_if.snk  up,
  e1_tx_bit_if.src  dn
);
  logic [1:0] buf_ff;
  logic [1:0] cnt_ff;
  logic       push;
  logic       pop;
  assign up.ready = (cnt_ff != 2'h2);
  assign dn.valid = (cnt_ff != 2'h0);
  assign dn.data  = buf_ff[0];
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buf_ff <= 2'h0;
      cnt_ff <= 2'h0;
    end else begin
      if (pop) begin
        buf_ff[0] <= (cnt_ff == 2'h2) ? buf_ff[1] : up.data;
      end
      if (push && !(pop ? (cnt_ff == 2'h2) : (cnt_ff == 2'h0)) ) begin
        buf_ff[cnt_ff - (pop ? 2'h1 : 2'h0) == 2'h0 ? 0 : 1] <= up.data;
      end
      if (push && (cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1))) begin
        buf_ff[0] <= up.data;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// file: hw/e1_tx_formatter.sv
`timescale 1ns/1ns
module e1_tx_formatter
  import e1_tx_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  // Transmit clock sampled in system domain
  input  wire logic transmit_primary_clock_in,
  // System side
  input  wire logic tx_multiframe_sync_in,
  input  wire logic tx_frame_sync_in,
  input  wire logic tx_serial_channel_data_in,
  input  wire logic tx_extra_data_in,
  input  wire logic tx_signaling_bits_in,
  input  wire logic tx_intl_national_bits_in,
  // Configuration pins
  input  wire logic host_mode_in,
  input  wire logic cas_enable_in,
  input  wire logic crc4_enable_in,
  input  wire logic intl_enable_in,
  input  wire logic natl_enable_in,
  input  wire logic alarm_ais_in,
  input  wire logic remote_alarm_in,
  // Timing outputs
  output logic      tx_channel_clock_out,
  output logic      tx_multiframe_out,
  output logic      tx_signaling_slot_marker_out,
  output logic      tx_alignment_frame_marker_out,
  // Line side
  output logic      line_out_positive_out,
  output logic      line_out_negative_out
);
  import e1_tx_pkg::*;

  // ==========================================================
  // Transmit clock edges
  logic       transmit_primary_clock_d_ff;
  logic       tfs_d_ff;
  logic       tms_d_ff;
  logic       rise_edge;
  logic       fall_edge;
  logic       fs_rise;
  logic       ms_rise;
  assign rise_edge = transmit_primary_clock_in && !transmit_primary_clock_d_ff;
  assign fall_edge = !transmit_primary_clock_in && transmit_primary_clock_d_ff;
  assign fs_rise   = tx_frame_sync_in && !tfs_d_ff;
  assign ms_rise   = tx_multiframe_sync_in && !tms_d_ff;

  // ==========================================================
  // Counters: bit, slot, frame
  logic [2:0] bit_ff;
  logic [4:0] slot_ff;
  logic [3:0] frm_ff;
  logic       frm_end;
  logic       do_fs;
  logic       do_ms;
  assign frm_end = (bit_ff == 3'h7) && (slot_ff == 5'h1F);
  assign do_fs   = rise_edge && fs_rise;
  assign do_ms   = rise_edge && ms_rise;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      transmit_primary_clock_d_ff <= 1'b0;
      tfs_d_ff  <= 1'b0;
      tms_d_ff  <= 1'b0;
    end else begin
      transmit_primary_clock_d_ff <= transmit_primary_clock_in;
      if (rise_edge) begin
        tfs_d_ff <= tx_frame_sync_in;
        tms_d_ff <= tx_multiframe_sync_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_ff  <= 3'h0;
      slot_ff <= 5'h00;
      frm_ff  <= 4'h0;
    end else if (do_ms) begin
      bit_ff  <= 3'h0;
      slot_ff <= 5'h00;
      frm_ff  <= 4'h0;
    end else if (do_fs) begin
      bit_ff  <= 3'h0;
      slot_ff <= 5'h00;
      frm_ff  <= frm_end ? frm_ff + 4'h1 : frm_ff;
    end else if (rise_edge) begin
      // Free-run when syncs are held low
      bit_ff <= bit_ff + 3'h1;
      if (bit_ff == 3'h7) begin
        slot_ff <= slot_ff + 5'h01;
        if (slot_ff == 5'h1F) begin
          frm_ff <= frm_ff + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Slot and frame decodes
  logic in_ts0;
  logic in_ts16;
  logic fas_frm;
  logic [3:0] bitno;
  assign in_ts0  = (slot_ff == SLOT_ALIGN);
  assign in_ts16 = (slot_ff == SLOT_SIG);
  assign fas_frm = !frm_ff[0];
  assign bitno   = {1'b0, bit_ff} + 4'h1;

  // ==========================================================
  // Falling-edge input samples
  logic sig_ff;
  logic xd_ff;
  logic ind_ff;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sig_ff <= 1'b0;
      xd_ff  <= 1'b1;
      ind_ff <= 1'b1;
    end else if (fall_edge) begin
      sig_ff <= tx_signaling_bits_in;
      if (in_ts16 && frm_ff == 4'h0 && (bitno == 4'h5 || bitno == 4'h7 || bitno == 4'h8)) begin
        xd_ff <= tx_extra_data_in;
      end
      if (in_ts0) begin
        ind_ff <= tx_intl_national_bits_in;
      end
    end
  end

  // ==========================================================
  // Channel data buffer, filled at the fall, drained at the rise
  // Spare entry keeps a sample if the drain comes late
  e1_tx_bit_if ser_up ();
  e1_tx_bit_if ser_dn ();
  assign ser_up.valid = fall_edge;
  assign ser_up.data  = tx_serial_channel_data_in;
  assign ser_dn.ready = rise_edge;
  e1_tx_skid u_ser_buf (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .up         (ser_up),
    .dn         (ser_dn)
  );

  // ==========================================================
  // CRC4 over the previous submultiframe
  logic [3:0] crc_ff;
  logic [3:0] crc_hold_ff;
  logic       crc_fb;
  logic       cur_bit;
  assign crc_fb = crc_ff[3] ^ cur_bit;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      crc_ff      <= CRC_FRAME_BITS;
      crc_hold_ff <= CRC_FRAME_BITS;
    end else if (rise_edge) begin
      if (frm_end && frm_ff[2:0] == 3'h7) begin
        crc_hold_ff <= {crc_ff[2:0], 1'b0} ^ (crc_fb ? CRC4_POLY : 4'h0);
        crc_ff      <= CRC_FRAME_BITS;
      end else begin
        crc_ff <= {crc_ff[2:0], 1'b0} ^ (crc_fb ? CRC4_POLY : 4'h0);
      end
    end
  end

  // ==========================================================
  // Bit formatting
  logic crc_on;
  logic cas_on;
  logic si_bit;
  assign crc_on = crc4_enable_in && host_mode_in;
  assign cas_on = cas_enable_in;
  assign si_bit = crc_on ? (frm_ff[0] ? (frm_ff[3:1] < 3'h6 ? frm_ff[1] ^ frm_ff[2] ^ 1'b0 : 1'b1)
                                      : crc_hold_ff[3 - frm_ff[2:1]])
                         : ((intl_enable_in && host_mode_in) ? ind_ff : 1'b1);

  always_comb begin
    cur_bit = ser_dn.data;
    if (alarm_ais_in) begin
      cur_bit = AIS_WORD[7 - bit_ff];
    end else if (in_ts0) begin
      if (bit_ff == 3'h0) begin
        cur_bit = si_bit;
      end else if (fas_frm) begin
        cur_bit = FAS_WORD[7 - bit_ff];
      end else if (bit_ff == 3'h1) begin
        cur_bit = 1'b1;
      end else if (bit_ff == 3'h2) begin
        cur_bit = remote_alarm_in;
      end else begin
        cur_bit = (natl_enable_in && host_mode_in) ? ind_ff : 1'b1;
      end
    end else if (in_ts16 && cas_on) begin
      if (frm_ff == 4'h0) begin
        cur_bit = (bit_ff < 3'h4) ? CAS_MF_WORD[7 - bit_ff] : (bit_ff == 3'h5 ? 1'b0 : xd_ff);
      end else begin
        cur_bit = sig_ff;
      end
    end
  end

  // ==========================================================
  // HDB3-free AMI bipolar encode
  logic polar_ff;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      polar_ff                      <= 1'b0;
      line_out_positive_out         <= 1'b0;
      line_out_negative_out         <= 1'b0;
      tx_channel_clock_out          <= 1'b0;
      tx_multiframe_out             <= 1'b0;
      tx_signaling_slot_marker_out  <= 1'b0;
      tx_alignment_frame_marker_out <= 1'b0;
    end else if (rise_edge) begin
      line_out_positive_out         <= cur_bit && !polar_ff;
      line_out_negative_out         <= cur_bit && polar_ff;
      polar_ff                      <= polar_ff ^ cur_bit;
      tx_channel_clock_out          <= (bit_ff < 3'h4);
      tx_multiframe_out             <= (frm_ff == 4'h0);
      tx_signaling_slot_marker_out  <= in_ts16;
      tx_alignment_frame_marker_out <= fas_frm;
    end
  end
endmodule

// file: testbench/e1_tx_formatter_asserts.sv
`timescale 1ns/1ns
module e1_tx_formatter_asserts (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic transmit_primary_clock_in,
  input wire logic tx_channel_clock_out,
  input wire logic tx_multiframe_out,
  input wire logic tx_signaling_slot_marker_out,
  input wire logic tx_alignment_frame_marker_out,
  input wire logic line_out_positive_out,
  input wire logic line_out_negative_out
);
  logic       transmit_primary_clock_ff;
  logic [3:0] sts_cnt_ff;
  logic [3:0] ch_cnt_ff;
  wire        transmit_primary_clock_rise = transmit_primary_clock_in & ~transmit_primary_clock_ff;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // =====
  // Transmit clock rises seen while a marker stands
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      transmit_primary_clock_ff <= 1'b0;
      sts_cnt_ff <= 4'h0;
      ch_cnt_ff <= 4'h0;
    end else begin
      transmit_primary_clock_ff <= transmit_primary_clock_in;
      sts_cnt_ff <= tx_signaling_slot_marker_out ? sts_cnt_ff + {3'h0, transmit_primary_clock_rise} : 4'h0;
      ch_cnt_ff <= tx_channel_clock_out ? ch_cnt_ff + {3'h0, transmit_primary_clock_rise} : 4'h0;
    end
  end
  a_line_ami_excl: assert property (!(line_out_positive_out && line_out_negative_out))
    else $error("both line outputs high");
  a_line_rise_only: assert property ($changed({line_out_positive_out, line_out_negative_out})
    |-> transmit_primary_clock_in) else $error("line moved in clock low");
  a_sts_eight_bits: assert property ($fell(tx_signaling_slot_marker_out) |-> sts_cnt_ff == 4'h8)
    else $error("slot marker length");
  a_chclk_four_bits: assert property ($fell(tx_channel_clock_out) |-> ch_cnt_ff == 4'h4)
    else $error("channel clock length");
  a_af_frame_edge: assert property ($changed(tx_alignment_frame_marker_out) |-> tx_channel_clock_out)
    else $error("alignment marker off slot start");
  a_mfo_frame_edge: assert property ($changed(tx_multiframe_out) |-> tx_channel_clock_out)
    else $error("multiframe out off slot start");
  a_sts_slot_edge: assert property ($rose(tx_signaling_slot_marker_out) |-> $rose(tx_channel_clock_out))
    else $error("slot marker off slot start");
  a_mfo_with_fas: assert property (tx_multiframe_out |-> tx_alignment_frame_marker_out)
    else $error("frame 0 without alignment");
  c_mfo: cover property ($rose(tx_multiframe_out));
  c_sts: cover property ($fell(tx_signaling_slot_marker_out));
  c_neg: cover property (line_out_negative_out);
endmodule
bind e1_tx_formatter e1_tx_formatter_asserts u_chk (.*);

// file: testbench/e1_tx_partner.sv
`timescale 1ns/1ns
// Backplane side: free-running transmit clock, one data bit per rise
module e1_tx_partner #(
  parameter int HALF = 12
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic data_bit_in,
  output logic      transmit_primary_clock_out,
  output logic      data_out,
  output int        rise_cnt_out
);
  int ph = 0;
  initial begin
    transmit_primary_clock_out = 1'b0;
    data_out = 1'b0;
    rise_cnt_out = 0;
  end
  // Whole system clocks a period, nearest to the line rate
  always @(posedge clk_sys_in) begin
    #1;
    ph = ph + 1;
    if (ph == HALF) begin
      ph = 0;
      transmit_primary_clock_out = ~transmit_primary_clock_out;
      if (transmit_primary_clock_out) begin
        data_out = data_bit_in;
        rise_cnt_out = sys_rst_in ? 0 : rise_cnt_out + 1;
      end
    end
  end
endmodule

// file: testbench/e1_transmit_formatter_tb.sv
`timescale 1ns/1ns
module e1_transmit_formatter_tb;
  logic clk_sys_in, sys_rst_in, transmit_primary_clock, ser, data_bit, mf_sync, feat_en, ais;
  logic chclk, mfo, sts, af, pos, neg;
  logic fs, sig, ind;
  int   rises;
  // Rise that carries bit 1 of frame 0
  int   frm0 = 801;
  int   bad_count = 0;
  int   compares = 0;
  e1_tx_partner u_far (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .data_bit_in(data_bit),
    .transmit_primary_clock_out(transmit_primary_clock), .data_out(ser), .rise_cnt_out(rises));
  e1_tx_formatter dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .transmit_primary_clock_in(transmit_primary_clock),
    .tx_multiframe_sync_in(mf_sync), .tx_frame_sync_in(fs), .tx_serial_channel_data_in(ser),
    .tx_extra_data_in(1'b0), .tx_signaling_bits_in(sig), .tx_intl_national_bits_in(ind),
    .host_mode_in(feat_en), .cas_enable_in(feat_en), .crc4_enable_in(feat_en), .intl_enable_in(feat_en),
    .natl_enable_in(feat_en), .alarm_ais_in(ais), .remote_alarm_in(1'b0), .tx_channel_clock_out(chclk),
    .tx_multiframe_out(mfo), .tx_signaling_slot_marker_out(sts), .tx_alignment_frame_marker_out(af),
    .line_out_positive_out(pos), .line_out_negative_out(neg));
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Outputs settle a few system clocks after rise n
  task automatic settle(input int n);
    while (rises < n) @(posedge clk_sys_in);
    repeat (6) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic look(input int n, input logic [3:0] exp);
    settle(n);
    chk({2'h0, chclk, mfo, sts, af}, {2'h0, exp});
  endtask
  task automatic end_of_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_frame();
    look(1, 4'hD);
    look(5, 4'h5);
    look(129, 4'hF);
    look(137, 4'hD);
    look(385, 4'hA);
    look(513, 4'h9);
  endtask
  // Sync edge placed just before a slot start
  task automatic t_mf_sync();
    look(799, 4'h0);
    repeat (8) @(posedge clk_sys_in);
    #1;
    mf_sync = 1'b1;
    look(800, 4'h0);
    look(801, 4'hD);
    mf_sync = 1'b0;
    look(1185, 4'hA);
  endtask
  // Frame sync mid-slot: next rise opens a frame of the same number
  task automatic t_frame_sync();
    int base;
    int f;
    int r;
    base = frm0 + ((rises - frm0) / 256 + 1) * 256;
    f = ((base - frm0) / 256) % 16;
    r = base + 100;
    settle(r - 1);
    fs = 1'b1;
    look(r, {1'b0, (f == 0), 1'b0, (f % 2 == 0)});
    look(r + 1, {1'b1, (f == 0), 1'b0, (f % 2 == 0)});
    fs = 1'b0;
    frm0 = r + 1 - f * 256;
    look(r + 129, {1'b1, (f == 0), 1'b1, (f % 2 == 0)});
  endtask
  // Odd frame: national bits from ind, slot 16 from signaling input
  task automatic t_sig_natl();
    int n;
    sig = 1'b1;
    data_bit = 1'b0;
    n = frm0 + ((rises - frm0) / 256 + 1) * 256;
    if (((n - frm0) / 256) % 2 == 0) n = n + 256;
    for (int i = 3; i < 8; i++) begin
      settle(n + i);
      chk({4'h0, pos, neg}, 6'h00);
    end
    for (int i = 128; i < 136; i++) begin
      settle(n + i);
      chk({4'h0, pos | neg, pos & neg}, 6'h02);
    end
    sig = 1'b0;
  endtask
  // Slot 5 of the next frame: marks must alternate polarity
  task automatic t_marks(input logic one, input logic alarm);
    int   n;
    logic last;
    data_bit = one;
    ais = alarm;
    n = frm0 + ((rises - frm0) / 256 + 1) * 256 + 40;
    last = 1'b0;
    for (int i = 0; i < 8; i++) begin
      settle(n + i);
      chk({4'h0, pos | neg, pos & neg}, {4'h0, one | alarm, 1'b0});
      if ((one | alarm) && i > 0) chk({5'h0, pos}, {5'h0, ~last});
      last = pos;
    end
  endtask
  initial begin
    sys_rst_in = 1'b1;
    data_bit = 1'b0;
    mf_sync = 1'b0;
    feat_en = 1'b1;
    ais = 1'b0;
    fs = 1'b0;
    sig = 1'b0;
    ind = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk({chclk, mfo, sts, af, pos, neg}, 6'h00);
    sys_rst_in = 1'b0;
    t_frame();
    t_mf_sync();
    t_frame_sync();
    t_sig_natl();
    t_marks(1'b1, 1'b0);
    t_marks(1'b0, 1'b1);
    t_marks(1'b0, 1'b0);
    end_of_test();
  end
  initial begin
    repeat (80000) @(posedge clk_sys_in);
    bad_count++;
    end_of_test();
  end
endmodule
